// >>> rtl/mode_select_pkg.sv
package mode_select_pkg;

   localparam logic [11:0] mode_control_addr = 12'h000;
   localparam int          mode_control_w    = 8;
   localparam int          expansion_enable_bit          = 7;
   localparam int          sense_hi_bit      = 1;
   localparam int          sense_lo_bit      = 0;

   localparam logic [1:0] pins_mode0 = 2'h0;
   localparam logic [1:0] pins_mode1 = 2'h1;
   localparam logic [1:0] pins_mode2 = 2'h2;

   // Edges after reset release: pins valid, then settled
   localparam logic [1:0] sense_load_cnt = 2'h2;
   localparam logic [1:0] sync_ready_cnt = 2'h3;

   localparam logic [1:0] resp_okay   = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;

   localparam int ea_width     = 24;
   localparam int normal_width = 16;

   // Bus slave phases, Gray along idle to answer
   typedef enum logic [1:0] {
      idle_st = 2'b00,
      resp_st = 2'b01
   } bus_state_type;

endpackage

// >>> rtl/operating_mode_select_control.sv
`timescale 1ns/1ns
module operating_mode_select_control (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        mode_pin_hi,
   input  wire logic        mode_pin_lo,
   input  wire logic [23:0] cpu_ea,
   output logic      [23:0] cpu_addr,
   output logic             advanced_addr,
   output logic             rom_enable,
   output logic             ext_bus_enable,
   output logic             mode_invalid,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   // Pin synchronisers: stage one feeds stage two only
   logic [1:0] pin_meta_r;
   logic [1:0] pin_sync_r;
   logic       expansion_enable_r;
   logic       sense_hi_r;
   logic       sense_lo_r;
   logic       mode1;
   logic       sense_load;
   logic [1:0] pins;

   assign pins = pin_sync_r;

   // Advanced addressing only on the 10 strap; decoded in several places
   function automatic logic is_adv(input logic [1:0] p);
      logic adv;
      adv = 1'b0;
      if (p == mode_select_pkg::pins_mode2) begin
         adv = 1'b1;
      end
      return adv;
   endfunction

   // Word decode shared by both channels; a single register is mapped
   function automatic logic reg_hit(input logic [11:0] a);
      logic hit;
      hit = 1'b0;
      if (a[11:2] == mode_select_pkg::mode_control_addr[11:2]) begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta_r <= 2'h0;
         pin_sync_r <= 2'h0;
      end else begin
         pin_meta_r <= {mode_pin_hi, mode_pin_lo};
         pin_sync_r <= pin_meta_r;
      end
   end

   // Pins held static (board's duty), so mode decodes straight from them
   assign mode1 = (pins == mode_select_pkg::pins_mode1);

   // First cycle after reset: sync chain not yet filled, wait one more edge
   logic [1:0] fill_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fill_r <= 2'h0;
      end else if (fill_r != mode_select_pkg::sync_ready_cnt) begin
         fill_r <= fill_r + 2'h1;
      end
   end
   assign sense_load = (fill_r == mode_select_pkg::sense_load_cnt);

   // Write channel: address and data taken in either order
   logic        aw_held_r;
   logic        w_held_r;
   logic [11:0] aw_addr_r;
   logic [7:0]  w_data_r;
   logic        w_strb0_r;
   logic        wr_go;
   logic        wr_hit;

   assign wr_go  = aw_held_r && w_held_r && !s_axi_bvalid;
   assign wr_hit = wr_go && reg_hit(aw_addr_r) && w_strb0_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r     <= 1'b0;
         w_held_r      <= 1'b0;
         aw_addr_r     <= 12'h000;
         w_data_r      <= 8'h00;
         w_strb0_r     <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end else begin
         s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[11:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r  <= 1'b1;
            w_data_r  <= s_axi_wdata[7:0];
            w_strb0_r <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= reg_hit(aw_addr_r) ? mode_select_pkg::resp_okay
                                               : mode_select_pkg::resp_slverr;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Extension enable: forced in mode 1, software owned in modes 2 and 3
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         expansion_enable_r <= 1'b0;
      end else if (sense_load) begin
         expansion_enable_r <= mode1;
      end else if (mode1) begin
         expansion_enable_r <= 1'b1;
      end else if (wr_hit) begin
         expansion_enable_r <= w_data_r[mode_select_pkg::expansion_enable_bit];
      end
   end

   // Read channel; a read of the mode register relatches the pins
   mode_select_pkg::bus_state_type rd_state_r;
   logic rd_hit;
   logic rd_take;
   assign rd_hit  = reg_hit(s_axi_araddr);
   // Accepted read of the mode register; also the sense-latch strobe
   assign rd_take = (rd_state_r == mode_select_pkg::idle_st) && s_axi_arvalid &&
                    s_axi_arready && rd_hit;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_r    <= mode_select_pkg::idle_st;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= 2'h0;
      end else begin
         case (rd_state_r)
            mode_select_pkg::idle_st: begin
               s_axi_arready <= !s_axi_arready;
               if (s_axi_arvalid && s_axi_arready) begin
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid  <= 1'b1;
                  rd_state_r    <= mode_select_pkg::resp_st;
                  if (rd_hit) begin
                     s_axi_rdata <= {24'h0, expansion_enable_r, 5'h00, pins};
                     s_axi_rresp <= mode_select_pkg::resp_okay;
                  end else begin
                     s_axi_rdata <= 32'h0;
                     s_axi_rresp <= mode_select_pkg::resp_slverr;
                  end
               end
            end
            default: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  rd_state_r   <= mode_select_pkg::idle_st;
               end
            end
         endcase
      end
   end

   // Sense latches: reset cancels, loaded from pins, refreshed on each read of the mode register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sense_hi_r <= 1'b0;
         sense_lo_r <= 1'b0;
      end else if (sense_load || rd_take) begin
         sense_hi_r <= pins[1];
         sense_lo_r <= pins[0];
      end
   end

   // Decoded mode outputs, all registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         advanced_addr  <= 1'b0;
         rom_enable     <= 1'b0;
         ext_bus_enable <= 1'b0;
         mode_invalid   <= 1'b0;
      end else begin
         advanced_addr  <= is_adv(pins);
         rom_enable     <= pins[1];
         ext_bus_enable <= expansion_enable_r;
         mode_invalid   <= (pins == mode_select_pkg::pins_mode0) &&
                           (fill_r == mode_select_pkg::sync_ready_cnt);
      end
   end

   // Normal addressing keeps only the low 16 bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_addr <= 24'h0;
      end else if (is_adv(pins)) begin
         cpu_addr <= cpu_ea;
      end else begin
         cpu_addr <= {8'h00, cpu_ea[mode_select_pkg::normal_width-1:0]};
      end
   end

   // Mode 1 forces extension on once settled
   mode1_expansion_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (fill_r == mode_select_pkg::sync_ready_cnt && mode1) |=> expansion_enable_r)
      else $error("expansion enable not forced in mode 1");

   // Extension enable leaves the block one cycle later
   ext_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
      1'b1 |=> ext_bus_enable == $past(expansion_enable_r))
      else $error("external bus enable lags wrongly");

   // Normal addressing clears the upper byte
   addr_trunc_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (pins != mode_select_pkg::pins_mode2) |=> cpu_addr[23:16] == 8'h00)
      else $error("upper address byte not dropped");

   // Reserved bits of a read answer are zero
   rsvd_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> s_axi_rdata[6:2] == 5'h00)
      else $error("reserved bits read nonzero");

   sequence rd_take_s;
      rd_take;
   endsequence
   // A read returns the pins it latched
   read_sense_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_take_s |=> s_axi_rvalid && s_axi_rdata[1:0] == {sense_hi_r, sense_lo_r})
      else $error("mode sense not captured on read");

   // Settled reset value of expansion enable follows the pins
   reset_expansion_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sense_load |=> expansion_enable_r == mode1)
      else $error("expansion enable reset value wrong");

   // Software write in modes 2 and 3 takes effect
   expansion_enable_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_hit && !mode1 && !sense_load) |=> expansion_enable_r == $past(w_data_r[7]))
      else $error("expansion enable write lost");

   // ROM enable mirrors the high pin
   rom_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
      1'b1 |=> rom_enable == $past(pins[1]))
      else $error("rom enable wrong for mode");

   // Reset wipes whatever the sense latches held
   sense_clear_a: assert property (@(posedge aclk)
      !aresetn |=> !sense_hi_r && !sense_lo_r)
      else $error("mode sense latches survive reset");

   // Settled strap levels land in the sense latches
   sense_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sense_load |=> {sense_hi_r, sense_lo_r} == $past(pins))
      else $error("mode sense reset value wrong");

   // Between loads and reads the sense latches keep their levels
   sense_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !(sense_load || rd_take) |=> $stable({sense_hi_r, sense_lo_r}))
      else $error("mode sense changed without a read");

   // A read answers with the strap levels of its own cycle
   sense_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_take |=> s_axi_rdata[1:0] == $past(pins))
      else $error("mode sense bits differ from pins");

   sequence m1_settled_s;
      (fill_r == mode_select_pkg::sync_ready_cnt) && mode1;
   endsequence
   // Mode 1 keeps the external bus on, two edges after it is seen
   ext_mode1_a: assert property (@(posedge aclk) disable iff (!aresetn)
      m1_settled_s |-> ##2 ext_bus_enable)
      else $error("mode 1 left the external bus off");

   // Modes 2 and 3 leave single-chip only through a write
   expansion_enable_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!wr_hit && !mode1 && !sense_load) |=> $stable(expansion_enable_r))
      else $error("expansion enable moved without a write");

   // A write with its low byte lane off leaves the register alone
   strobe_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_go && !w_strb0_r && !sense_load) |=> $stable(expansion_enable_r))
      else $error("unstrobed write changed expansion enable");

   // Advanced flag follows the 10 strap one edge later
   adv_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      1'b1 |=> advanced_addr == ($past(pins) == mode_select_pkg::pins_mode2))
      else $error("advanced addressing flag wrong");

endmodule

// >>> bench/strap_model.sv
`timescale 1ns/1ns
// Board straps: a level only moves while the chip sits in reset
module strap_model (
   input  wire logic       aresetn,
   input  wire logic [1:0] want,
   output logic            mode_pin_hi,
   output logic            mode_pin_lo
);
   logic [1:0] held_r;
   // All-zero strap is never offered, it has no function
   always_latch begin
      if (!aresetn && want != 2'h0) begin
         held_r <= want;
      end
   end
   assign mode_pin_hi = held_r[1];
   assign mode_pin_lo = held_r[0];
endmodule

// >>> bench/operating_mode_select_control_tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end
module operating_mode_select_control_tb;
   logic        aclk = 1'b0, aresetn = 1'b0, mode_pin_hi, mode_pin_lo;
   logic [1:0]  strap = 2'h1;
   logic [23:0] cpu_ea = 24'h0, cpu_addr;
   logic        advanced_addr, rom_enable, ext_bus_enable, mode_invalid;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          err_total = 0, n_compared = 0;
   localparam logic [11:0] reg_a = mode_select_pkg::mode_control_addr;

   // Free-running 100 MHz clock
   always #5 aclk = ~aclk;

   strap_model strap_model_inst (.aresetn(aresetn), .want(strap),
      .mode_pin_hi(mode_pin_hi), .mode_pin_lo(mode_pin_lo));
   operating_mode_select_control operating_mode_select_control_inst (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .mode_pin_hi   (mode_pin_hi),
      .mode_pin_lo   (mode_pin_lo),
      .cpu_ea        (cpu_ea),
      .cpu_addr      (cpu_addr),
      .advanced_addr (advanced_addr),
      .rom_enable    (rom_enable),
      .ext_bus_enable(ext_bus_enable),
      .mode_invalid  (mode_invalid),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready)
   );

   // Address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   // Straps change only across a reset; pins settle before the first request
   task automatic restrap(input logic [1:0] m);
      strap <= m;
      cpu_ea <= {8'ha5, 8'h3c, 6'h0, m};
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (5) @(posedge aclk);
   endtask

   // One strap setting: decoded outputs, reset image, then write behaviour
   task automatic mode_scenario(input logic [1:0] m);
      logic [31:0] d, wv[3];
      logic [1:0]  r;
      logic        ex;
      wv = '{32'h7f, 32'h80, 32'h0};
      restrap(m);
      ex = (m == 2'h1);
      `CHK("advanced", m == 2'h2, advanced_addr)
      `CHK("rom_en", m[1], rom_enable)
      `CHK("ext_bus", ex, ext_bus_enable)
      `CHK("invalid", 1'b0, mode_invalid)
      `CHK("addr", m == 2'h2 ? cpu_ea : {8'h00, cpu_ea[15:0]}, cpu_addr)
      axi_rd(reg_a, d, r);
      `CHK("reset image", {24'h0, ex, 5'h0, m}, d)
      `CHK("rresp", mode_select_pkg::resp_okay, r)
      axi_wr(reg_a, 32'hff, 4'h0, r);
      axi_rd(reg_a, d, r);
      `CHK("no strobe", {24'h0, ex, 5'h0, m}, d)
      foreach (wv[i]) begin
         axi_wr(reg_a, wv[i], 4'h1, r);
         `CHK("bresp", mode_select_pkg::resp_okay, r)
         axi_rd(reg_a, d, r);
         `CHK("reg", {24'h0, ex | wv[i][7], 5'h0, m}, d)
         `CHK("ext_bus", ex | wv[i][7], ext_bus_enable)
      end
   endtask

   // Off-map accesses are refused and leave the register alone
   task automatic unmapped_scenario;
      logic [31:0] d;
      logic [1:0]  r;
      axi_wr(12'h008, 32'h80, 4'h1, r);
      `CHK("wr slverr", mode_select_pkg::resp_slverr, r)
      axi_rd(12'h004, d, r);
      `CHK("rd slverr", mode_select_pkg::resp_slverr, r)
      `CHK("rd zero", 32'h0, d)
      axi_rd(reg_a, d, r);
      `CHK("kept", 32'h3, d)
   endtask

   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      mode_scenario(2'h1);
      mode_scenario(2'h2);
      mode_scenario(2'h3);
      unmapped_scenario();
      complete_run();
   end

   // Watchdog: the whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      complete_run();
   end
endmodule
